// *** hssc_pkg.sv ***
// Package with register map, field positions, commands and timing constants for home search.
package hssc_pkg;
  localparam logic [11:0] HSSC_ADDR_MODE_WR = 12'h000;
  localparam logic [11:0] HSSC_ADDR_CMD = 12'h004;
  localparam logic [11:0] HSSC_ADDR_LEVEL = 12'h008;
  localparam logic [11:0] HSSC_ADDR_DRIVE_SPEED = 12'h00C;
  localparam logic [11:0] HSSC_ADDR_HOME_SPEED = 12'h010;
  localparam logic [11:0] HSSC_ADDR_MODE1 = 12'h014;
  localparam logic [11:0] HSSC_ADDR_MODE2 = 12'h018;
  localparam logic [11:0] HSSC_ADDR_STATUS = 12'h01C;
  localparam logic [11:0] HSSC_ADDR_PROGRESS = 12'h020;
  localparam logic [11:0] HSSC_ADDR_ACK = 12'h024;

  localparam logic [7:0] HSSC_CMD_DRIVE_SPEED = 8'h05;
  localparam logic [7:0] HSSC_CMD_HOME_SPEED = 8'h14;
  localparam logic [7:0] HSSC_CMD_MODE1 = 8'h23;
  localparam logic [7:0] HSSC_CMD_MODE2 = 8'h24;
  localparam logic [7:0] HSSC_CMD_EXECUTE = 8'h5A;
  localparam logic [7:0] HSSC_CMD_DEC_STOP = 8'h56;
  localparam logic [7:0] HSSC_CMD_INST_STOP = 8'h57;

  // Mode word one fields.
  localparam int HSSC_M1_STEP_ONE_ENABLE = 0;
  localparam int HSSC_M1_STEP_ONE_DIRECTION = 1;
  localparam int HSSC_M1_STEP_ONE_INPUT_SEL_LO = 2;
  localparam int HSSC_M1_STEP_ONE_INPUT_SEL_HI = 3;
  localparam int HSSC_M1_STEP_TWO_ENABLE = 4;
  localparam int HSSC_M1_STEP_TWO_DIRECTION = 5;
  localparam int HSSC_M1_STEP_TWO_INPUT_SEL = 6;
  localparam int HSSC_M1_STEP_TWO_CLEAR_PULSE_EN = 7;
  localparam int HSSC_M1_STEP_TWO_REAL_POS_CLEAR = 8;
  localparam int HSSC_M1_STEP_TWO_LOGIC_POS_CLEAR = 9;
  localparam int HSSC_M1_STEP_THREE_ENABLE = 10;
  localparam int HSSC_M1_STEP_THREE_DIRECTION = 11;
  localparam int HSSC_M1_STEP_THREE_CLEAR_PULSE_EN = 12;
  localparam int HSSC_M1_STEP_THREE_REAL_POS_CLEAR = 13;
  localparam int HSSC_M1_STEP_THREE_LOGIC_POS_CLEAR = 14;
  localparam int HSSC_M1_STEP_FOUR_ENABLE = 15;
  // Mode word two fields.
  localparam int HSSC_M2_RCLR = 1;
  localparam int HSSC_M2_LCLR = 2;
  localparam int HSSC_M2_CLEAR_PULSE_POLARITY = 3;
  localparam int HSSC_M2_DCP_LO = 4;
  localparam int HSSC_M2_STEP_TIMER_ENABLE = 7;
  localparam int HSSC_M2_HTM_LO = 8;

  // Input level register bits: one means active high.
  localparam int HSSC_LVL_ZERO = 0;
  localparam int HSSC_LVL_HOME = 1;
  localparam int HSSC_LVL_INDEX = 2;
  localparam int HSSC_LVL_PLIM = 3;
  localparam int HSSC_LVL_NLIM = 4;

  // Ack register bits written by the motion engine side.
  localparam int HSSC_ACK_RECOVER = 0;

  localparam int HSSC_CLK_HZ = 25_000_000;
  localparam int HSSC_REF_HZ = 16_000_000;
  localparam logic [1:0] HSSC_SEL_ZERO = 2'b00;
  localparam logic [1:0] HSSC_SEL_HOME = 2'b01;
  localparam logic [1:0] HSSC_SEL_LIMIT = 2'b10;
  localparam logic [15:0] HSSC_MODE_RESET = 16'h0000;
  localparam logic [31:0] HSSC_ZERO_WORD = 32'h0000_0000;

  // Pulse times in microseconds and timer times in milliseconds, scaled to pclk cycles at 25 MHz.
  localparam int HSSC_PULSE_US [8] = '{10, 20, 100, 200, 1000, 2000, 10000, 20000};
  localparam int HSSC_TIMER_MS [8] = '{1, 2, 10, 20, 100, 200, 500, 1000};
  localparam int HSSC_US_CYCLES = HSSC_CLK_HZ / 1_000_000;

  typedef enum logic [9:0] {
    HSSC_IDLE = 10'b00_0000_0001,
    HSSC_STEP1 = 10'b00_0000_0010,
    HSSC_STEP2 = 10'b00_0000_0100,
    HSSC_RECOV = 10'b00_0000_1000,
    HSSC_STEP3 = 10'b00_0001_0000,
    HSSC_STEP4 = 10'b00_0010_0000,
    HSSC_PULSE = 10'b00_0100_0000,
    HSSC_WAIT = 10'b00_1000_0000,
    HSSC_RWAIT = 10'b01_0000_0000,
    HSSC_NEXT = 10'b10_0000_0000
  } hssc_state_e;
endpackage : hssc_pkg

// *** hssc_home_search.sv ***
// Home search step sequencer with mode words, speeds, clear pulse and step timer.
//
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/100ps
module hssc_home_search #(
  parameter int SPEED_W = 32,
  parameter int TIME_SCALE_DIV = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic zero_stop_input,
  input wire logic home_input,
  input wire logic encoder_index_input,
  input wire logic positive_limit_input,
  input wire logic negative_limit_input,
  input wire logic motion_done,
  output logic servo_error_clear_out,
  output logic [SPEED_W-1:0] active_speed,
  output logic move_active,
  output logic move_negative,
  output logic [2:0] active_step,
  output logic real_pos_clear,
  output logic logic_pos_clear
);
  import hssc_pkg::*;

  logic [15:0] mode_write_register_ff;
  logic [15:0] home_search_mode_word_one_ff;
  logic [15:0] mode_two_ff;
  logic [4:0] input_level_register_ff;
  logic [SPEED_W-1:0] drive_speed_ff;
  logic [SPEED_W-1:0] home_search_speed_ff;
  logic [4:0] sync1_ff;
  logic [4:0] sync2_ff;
  logic [4:0] in_act;
  logic det_ff;
  logic det_now;
  logic det_rise;
  hssc_state_e state_ff;
  hssc_state_e nxt_state;
  logic [2:0] step_ff;
  logic [2:0] nxt_step;
  logic [31:0] count_ff;
  logic [31:0] nxt_count;
  logic clr_pulse_ff;
  logic pulse_pending_ff;
  logic real_clr_ff;
  logic logic_clr_ff;
  logic wr_en;
  logic cmd_wr;
  logic [7:0] cmd;
  logic start_cmd;
  logic stop_cmd;
  logic recover_req;

  // Cycles of a time in microseconds, scaled from the 25 MHz pclk and divided by TIME_SCALE_DIV.
  function automatic logic [31:0] hssc_cycles(input int us);
    longint c;
    c = longint'(us) * HSSC_US_CYCLES / TIME_SCALE_DIV;
    if (c < 1) begin
      c = 1;
    end
    return c[31:0];
  endfunction : hssc_cycles

  // Step enable for step number one through four.
  function automatic logic hssc_step_en(input logic [15:0] m, input logic [2:0] s);
    case (s)
      3'd1: return m[HSSC_M1_STEP_ONE_ENABLE];
      3'd2: return m[HSSC_M1_STEP_TWO_ENABLE];
      3'd3: return m[HSSC_M1_STEP_THREE_ENABLE];
      3'd4: return m[HSSC_M1_STEP_FOUR_ENABLE];
      default: return 1'b0;
    endcase
  endfunction : hssc_step_en

  function automatic logic hssc_dir(input logic [15:0] m, input logic [2:0] s);
    case (s)
      3'd1: return m[HSSC_M1_STEP_ONE_DIRECTION];
      3'd2: return m[HSSC_M1_STEP_TWO_DIRECTION];
      3'd3: return m[HSSC_M1_STEP_THREE_DIRECTION];
      default: return 1'b0;
    endcase
  endfunction : hssc_dir

  // APB slave with zero wait states; unmapped addresses answer with an error.
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign cmd_wr = wr_en && (paddr == HSSC_ADDR_CMD);
  assign cmd = pwdata[7:0];
  assign start_cmd = cmd_wr && (cmd == HSSC_CMD_EXECUTE);
  assign stop_cmd = cmd_wr && (cmd == HSSC_CMD_DEC_STOP || cmd == HSSC_CMD_INST_STOP);
  assign recover_req = wr_en && (paddr == HSSC_ADDR_ACK) && pwdata[HSSC_ACK_RECOVER];

  always_comb begin
    pslverr = 1'b0;
    if (psel && penable) begin
      case (paddr)
        HSSC_ADDR_MODE_WR, HSSC_ADDR_CMD, HSSC_ADDR_LEVEL, HSSC_ADDR_DRIVE_SPEED,
        HSSC_ADDR_HOME_SPEED, HSSC_ADDR_MODE1, HSSC_ADDR_MODE2, HSSC_ADDR_STATUS,
        HSSC_ADDR_PROGRESS, HSSC_ADDR_ACK: pslverr = 1'b0;
        default: pslverr = 1'b1;
      endcase
    end
  end

  always_comb begin
    prdata = HSSC_ZERO_WORD;
    case (paddr)
      HSSC_ADDR_LEVEL: prdata = {27'd0, input_level_register_ff};
      HSSC_ADDR_DRIVE_SPEED: prdata = 32'(drive_speed_ff);
      HSSC_ADDR_HOME_SPEED: prdata = 32'(home_search_speed_ff);
      HSSC_ADDR_MODE1: prdata = {16'd0, home_search_mode_word_one_ff};
      HSSC_ADDR_MODE2: prdata = {16'd0, mode_two_ff};
      HSSC_ADDR_STATUS: prdata = {22'd0, state_ff};
      HSSC_ADDR_PROGRESS: prdata = {24'd0, det_now, clr_pulse_ff, 3'd0, step_ff};
      default: prdata = HSSC_ZERO_WORD;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_write_register_ff <= HSSC_MODE_RESET;
      input_level_register_ff <= '1;
    end else if (wr_en && paddr == HSSC_ADDR_MODE_WR) begin
      mode_write_register_ff <= pwdata[15:0];
    end else if (wr_en && paddr == HSSC_ADDR_LEVEL) begin
      input_level_register_ff <= pwdata[4:0];
    end
  end

  // Speeds are loaded from the mode write register by their command codes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_speed_ff <= '0;
      home_search_speed_ff <= '0;
    end else if (cmd_wr && cmd == HSSC_CMD_DRIVE_SPEED) begin
      drive_speed_ff <= SPEED_W'(mode_write_register_ff);
    end else if (cmd_wr && cmd == HSSC_CMD_HOME_SPEED) begin
      home_search_speed_ff <= SPEED_W'(mode_write_register_ff);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      home_search_mode_word_one_ff <= HSSC_MODE_RESET;
      mode_two_ff <= HSSC_MODE_RESET;
    end else if (cmd_wr && cmd == HSSC_CMD_MODE1) begin
      home_search_mode_word_one_ff <= mode_write_register_ff;
    end else if (cmd_wr && cmd == HSSC_CMD_MODE2) begin
      mode_two_ff <= mode_write_register_ff;
    end
  end

  // Two flip-flops on every pin before any logic reads it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= {negative_limit_input, positive_limit_input, encoder_index_input,
                   home_input, zero_stop_input};
      sync2_ff <= sync1_ff;
    end
  end

  assign in_act = ~(sync2_ff ^ input_level_register_ff);

  // Detection input of the running step.
  always_comb begin
    logic lim;
    logic neg;
    neg = hssc_dir(home_search_mode_word_one_ff, step_ff);
    lim = neg ? in_act[HSSC_LVL_NLIM] : in_act[HSSC_LVL_PLIM];
    det_now = 1'b0;
    case (step_ff)
      3'd1: begin
        case (home_search_mode_word_one_ff[HSSC_M1_STEP_ONE_INPUT_SEL_HI:HSSC_M1_STEP_ONE_INPUT_SEL_LO])
          HSSC_SEL_ZERO: det_now = in_act[HSSC_LVL_ZERO];
          HSSC_SEL_HOME: det_now = in_act[HSSC_LVL_HOME];
          HSSC_SEL_LIMIT: det_now = lim;
          default: det_now = 1'b0;
        endcase
      end
      // Same input as step 1 is accepted without any check.
      3'd2: det_now = home_search_mode_word_one_ff[HSSC_M1_STEP_TWO_INPUT_SEL] ? lim
                                                            : in_act[HSSC_LVL_HOME];
      3'd3: det_now = in_act[HSSC_LVL_INDEX];
      default: det_now = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      det_ff <= 1'b0;
    end else begin
      det_ff <= det_now;
    end
  end

  assign det_rise = det_now && !det_ff;

  // Sequencer.
  always_comb begin
    logic [2:0] ns;
    logic pulse_go;
    logic [2:0] wcode;
    logic [2:0] tcode;
    wcode = mode_two_ff[HSSC_M2_DCP_LO +: 3];
    tcode = mode_two_ff[HSSC_M2_HTM_LO +: 3];
    nxt_state = state_ff;
    nxt_step = step_ff;
    nxt_count = count_ff;
    ns = step_ff + 3'd1;
    pulse_go = (step_ff == 3'd2 && home_search_mode_word_one_ff[HSSC_M1_STEP_TWO_CLEAR_PULSE_EN]) ||
               (step_ff == 3'd3 && home_search_mode_word_one_ff[HSSC_M1_STEP_THREE_CLEAR_PULSE_EN]);
    case (state_ff)
      HSSC_IDLE: begin
        if (start_cmd) begin
          nxt_step = 3'd1;
          nxt_state = HSSC_NEXT;
        end
      end
      HSSC_NEXT: begin
        if (step_ff > 3'd4) begin
          nxt_state = HSSC_IDLE;
          nxt_step = 3'd0;
        end else if (!hssc_step_en(home_search_mode_word_one_ff, step_ff)) begin
          nxt_step = ns;
        end else begin
          case (step_ff)
            3'd1: nxt_state = HSSC_STEP1;
            3'd2: nxt_state = HSSC_STEP2;
            3'd3: nxt_state = HSSC_STEP3;
            default: nxt_state = HSSC_STEP4;
          endcase
        end
      end
      HSSC_STEP1, HSSC_STEP2, HSSC_STEP3, HSSC_STEP4: begin
        if (state_ff == HSSC_STEP2 && recover_req) begin
          nxt_state = HSSC_RECOV;
        end else if (state_ff == HSSC_STEP4 ? motion_done : det_now) begin
          if (pulse_pending_ff || (pulse_go && det_rise)) begin
            nxt_state = HSSC_PULSE;
            nxt_count = hssc_cycles(HSSC_PULSE_US[wcode]) - 32'd1;
          end else begin
            nxt_state = HSSC_WAIT;
            nxt_count = hssc_cycles(HSSC_TIMER_MS[tcode] * 1000) - 32'd1;
          end
        end
      end
      HSSC_RECOV: begin
        if (motion_done) begin
          nxt_state = HSSC_RWAIT;
          nxt_count = hssc_cycles(HSSC_TIMER_MS[tcode] * 1000) - 32'd1;
        end
      end
      HSSC_PULSE: begin
        if (count_ff == 32'd0) begin
          nxt_state = HSSC_WAIT;
          nxt_count = hssc_cycles(HSSC_TIMER_MS[tcode] * 1000) - 32'd1;
        end else begin
          nxt_count = count_ff - 32'd1;
        end
      end
      HSSC_WAIT, HSSC_RWAIT: begin
        // One shared enable and interval for every timer.
        if (!mode_two_ff[HSSC_M2_STEP_TIMER_ENABLE] || count_ff == 32'd0) begin
          nxt_state = (state_ff == HSSC_RWAIT) ? HSSC_STEP2 : HSSC_NEXT;
          nxt_step = (state_ff == HSSC_RWAIT) ? step_ff : ns;
        end else begin
          nxt_count = count_ff - 32'd1;
        end
      end
      default: nxt_state = HSSC_IDLE;
    endcase
    if (stop_cmd) begin
      nxt_state = HSSC_IDLE;
      nxt_step = 3'd0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= HSSC_IDLE;
      step_ff <= 3'd0;
      count_ff <= 32'd0;
    end else begin
      state_ff <= nxt_state;
      step_ff <= nxt_step;
      count_ff <= nxt_count;
    end
  end

  // A rising edge seen while searching earns the pulse even if the stop lags.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_pending_ff <= 1'b0;
    end else if (state_ff != HSSC_STEP2 && state_ff != HSSC_STEP3) begin
      pulse_pending_ff <= 1'b0;
    end else if (det_rise && ((step_ff == 3'd2 && home_search_mode_word_one_ff[HSSC_M1_STEP_TWO_CLEAR_PULSE_EN]) ||
                 (step_ff == 3'd3 && home_search_mode_word_one_ff[HSSC_M1_STEP_THREE_CLEAR_PULSE_EN]))) begin
      pulse_pending_ff <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clr_pulse_ff <= 1'b0;
    end else begin
      clr_pulse_ff <= (nxt_state == HSSC_PULSE);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      real_clr_ff <= 1'b0;
      logic_clr_ff <= 1'b0;
    end else begin
      real_clr_ff <= 1'b0;
      logic_clr_ff <= 1'b0;
      if (state_ff == HSSC_STEP2 && (nxt_state == HSSC_PULSE || nxt_state == HSSC_WAIT)) begin
        real_clr_ff <= home_search_mode_word_one_ff[HSSC_M1_STEP_TWO_REAL_POS_CLEAR];
        logic_clr_ff <= home_search_mode_word_one_ff[HSSC_M1_STEP_TWO_LOGIC_POS_CLEAR];
      end else if (state_ff == HSSC_STEP3 &&
                   (nxt_state == HSSC_PULSE || nxt_state == HSSC_WAIT)) begin
        real_clr_ff <= home_search_mode_word_one_ff[HSSC_M1_STEP_THREE_REAL_POS_CLEAR];
        logic_clr_ff <= home_search_mode_word_one_ff[HSSC_M1_STEP_THREE_LOGIC_POS_CLEAR];
      end else if (state_ff == HSSC_STEP4 && nxt_state == HSSC_WAIT) begin
        real_clr_ff <= mode_two_ff[HSSC_M2_RCLR];
        logic_clr_ff <= mode_two_ff[HSSC_M2_LCLR];
      end
    end
  end

  assign servo_error_clear_out = clr_pulse_ff ^ mode_two_ff[HSSC_M2_CLEAR_PULSE_POLARITY];
  assign real_pos_clear = real_clr_ff;
  assign logic_pos_clear = logic_clr_ff;
  assign active_step = step_ff;
  assign move_active = state_ff inside {HSSC_STEP1, HSSC_STEP2, HSSC_STEP3, HSSC_STEP4,
                                         HSSC_RECOV};
  // Recovery runs opposite to the search at drive speed; host keeps HV below SV.
  assign move_negative = (state_ff == HSSC_RECOV) ^ hssc_dir(home_search_mode_word_one_ff,
                                                             step_ff);
  assign active_speed = (state_ff inside {HSSC_STEP2, HSSC_STEP3}) ? home_search_speed_ff
                                                                    : drive_speed_ff;

  chk_pulse_after_step: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == HSSC_PULSE) |-> !(nxt_state inside {HSSC_STEP3, HSSC_STEP4}))
    else $error("next step started during clear pulse");
  chk_pulse_enable: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(clr_pulse_ff) |-> $past(step_ff) inside {3'd2, 3'd3})
    else $error("clear pulse outside steps two and three");
  chk_timer_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == HSSC_WAIT && mode_two_ff[HSSC_M2_STEP_TIMER_ENABLE] && count_ff != 32'd0 && !stop_cmd)
    |=> state_ff == HSSC_WAIT)
    else $error("timer left early");
  chk_recover_timer: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == HSSC_RWAIT && !stop_cmd && nxt_state != HSSC_RWAIT) |=> state_ff == HSSC_STEP2)
    else $error("recovery did not resume step two");
  chk_mode_latch: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_wr && cmd == HSSC_CMD_MODE1) |=>
    home_search_mode_word_one_ff == $past(mode_write_register_ff))
    else $error("mode word one not latched");
  chk_skip_step: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == HSSC_NEXT && step_ff == 3'd1 && !home_search_mode_word_one_ff[HSSC_M1_STEP_ONE_ENABLE]
     && !stop_cmd) |=> state_ff != HSSC_STEP1)
    else $error("disabled step ran");
  chk_index_step3: assert property (@(posedge pclk) disable iff (!presetn)
    step_ff == 3'd3 |-> det_now == in_act[HSSC_LVL_INDEX])
    else $error("step three not on index input");
  chk_speed_load: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_wr && cmd == HSSC_CMD_HOME_SPEED) |=>
    home_search_speed_ff == SPEED_W'($past(mode_write_register_ff)))
    else $error("home speed not loaded");
endmodule : hssc_home_search

// *** hssc_axis_model.sv ***
// Behavioural model of the axis sensors and the motion engine around the home search block.
`timescale 1ns/100ps
module hssc_axis_model #(
  parameter int DONE_DELAY = 20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [4:0] hit,
  input wire logic move_active,
  output logic [4:0] pins,
  output logic motion_done
);
  import hssc_pkg::*;
  int cnt_ff;
  // All sensors are wired active high, which matches the level register written by the host.
  assign pins = hit;
  // A move reports completion once, after a fixed travel time; a longer delay models a slow axis.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 0;
      motion_done <= 1'b0;
    end else begin
      motion_done <= move_active && (cnt_ff == DONE_DELAY - 1);
      cnt_ff <= move_active ? cnt_ff + 1 : 0;
    end
  end
endmodule : hssc_axis_model

// *** hssc_testbench.sv ***
// Self-checking testbench for the home search step sequencer.
`timescale 1ns/100ps
module testbench;
  import hssc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, motion_done, clr;
  logic move_active, move_negative, real_pos_clear, logic_pos_clear, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, active_speed;
  logic [4:0] hit, pins;
  logic [2:0] active_step;
  int err_total, samples_checked, n, w, rp, lp, cp;
  hssc_home_search #(.TIME_SCALE_DIV(10)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .zero_stop_input(pins[0]), .home_input(pins[1]),
    .encoder_index_input(pins[2]), .positive_limit_input(pins[3]),
    .negative_limit_input(pins[4]), .motion_done(motion_done), .servo_error_clear_out(clr),
    .active_speed(active_speed), .move_active(move_active), .move_negative(move_negative),
    .active_step(active_step), .real_pos_clear(real_pos_clear),
    .logic_pos_clear(logic_pos_clear));
  hssc_axis_model i_model (.pclk(pclk), .presetn(presetn), .hit(hit),
    .move_active(move_active), .pins(pins), .motion_done(motion_done));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (real_pos_clear === 1'b1) rp++;
    if (logic_pos_clear === 1'b1) lp++;
    // Cycles with the clear output high, whatever its polarity setting.
    if (clr === 1'b1) cp++;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic load(input logic [7:0] c, input logic [31:0] d);
    apb(1'b1, HSSC_ADDR_MODE_WR, d);
    apb(1'b1, HSSC_ADDR_CMD, {24'h0000_00, c});
  endtask : load
  task automatic wait_step(input logic [2:0] s);
    n = 0;
    while (active_step !== s && n < 4000) begin
      @(posedge pclk);
      n++;
    end
    check("step", active_step, s);
  endtask : wait_step
  // Waits for the clear output to reach lvl, then counts the cycles it stays there.
  task automatic pulse(input logic lvl);
    n = 0;
    w = 0;
    while (clr !== lvl && n < 4000) begin
      @(posedge pclk);
      n++;
    end
    while (clr === lvl && w < 4000) begin
      @(posedge pclk);
      w++;
    end
  endtask : pulse
  task automatic stop_test();
    if (err_total == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test
  initial begin
    repeat (60000) @(posedge pclk);
    err_total++;
    stop_test();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, hit} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    check("idle_out", {clr, active_step}, 4'h0);
    apb(1'b0, HSSC_ADDR_MODE1, 0);
    check("mode1_rst", q, {16'h0000, HSSC_MODE_RESET});
    apb(1'b0, 12'h0FC, 0);
    check("unmapped", e, 1);
    apb(1'b1, HSSC_ADDR_LEVEL, 32'h0000_001F);
    load(HSSC_CMD_DRIVE_SPEED, 32'h0000_1234);
    load(HSSC_CMD_HOME_SPEED, 32'h0000_0056);
    apb(1'b1, HSSC_ADDR_DRIVE_SPEED, 32'h0000_7777);
    apb(1'b0, HSSC_ADDR_DRIVE_SPEED, 0);
    check("drv_ro", q, 32'h0000_1234);
    load(HSSC_CMD_MODE1, 32'h0000_0D9B);
    apb(1'b0, HSSC_ADDR_MODE1, 0);
    check("mode1", q, 32'h0000_0D9B);
    apb(1'b1, HSSC_ADDR_CMD, {24'h0000_00, HSSC_CMD_EXECUTE});
    wait_step(1);
    check("s1", {move_negative, active_speed[15:0]}, {1'b1, 16'h1234});
    hit <= 5'b0_1000;
    repeat (10) @(posedge pclk);
    check("s1_plim", active_step, 1);
    hit <= 5'b1_0000;
    wait_step(2);
    hit <= 5'b0_0000;
    repeat (4) @(posedge pclk);
    check("s2", {move_negative, active_speed[15:0]}, {1'b0, 16'h0056});
    hit <= 5'b0_0010;
    pulse(1'b1);
    check("s2_pulse", w, 25);
    check("s2_hold", active_step === 3'd3, 0);
    wait_step(3);
    check("no_timer", n < 10, 1);
    check("s2_clr", {rp[7:0], lp[7:0]}, 16'h0100);
    hit <= 5'b0_0100;
    wait_step(0);
    check("s3_nopulse", cp, 25);
    check("s3_clr", {rp[7:0], lp[7:0]}, 16'h0100);
    hit <= 5'b0_0000;
    load(HSSC_CMD_MODE2, 32'h0000_008A);
    load(HSSC_CMD_MODE1, 32'h0000_9400);
    rp = 0;
    apb(1'b1, HSSC_ADDR_CMD, {24'h0000_00, HSSC_CMD_EXECUTE});
    check("idle_hi", clr, 1);
    wait_step(3);
    hit <= 5'b0_0100;
    pulse(1'b0);
    check("s3_pulse", w, 25);
    hit <= 5'b0_0000;
    wait_step(4);
    check("timer", n >= 2500 && n <= 2510, 1);
    wait_step(0);
    check("s4_clr", {rp[7:0], lp[7:0], clr}, 17'h0_0201);
    stop_test();
  end
endmodule : testbench
